// ===== logic/smrc_consts.svh
// Constants of the system mode and reset controller
`ifndef SMRC_CONSTS_SVH
`define SMRC_CONSTS_SVH

// Peripheral window: 16 Kbyte at the base of the peripheral region
`define SMRC_BASE_ADDR       32'hFF000000
`define SMRC_WIN_BITS        14
`define SMRC_OFF_MODE        14'h0000
`define SMRC_OFF_IDENT       14'h0004
`define SMRC_OFF_CAUSE       14'h0008
`define SMRC_OFF_CLKST       14'h000C

// Mode register fields
`define SMRC_MODE_RESET      32'h000B0340
`define SMRC_MODE_WMASK      32'h3FFF53CB
`define SMRC_REMAP_BIT       0
`define SMRC_DSP_REL_BIT     1
`define SMRC_DSP_INH_BIT     3
`define SMRC_LP_BIT          6
`define SMRC_SLOW_HOST_BIT   7
`define SMRC_LPCS_LSB        8
`define SMRC_SOFT_HIGH_BIT   10
`define SMRC_SOFT_LOW_BIT    11

// Identifier register fields
`define SMRC_PKG_BIT         16

// Reset cause, one-hot
`define SMRC_CAUSE_HW        3'h1
`define SMRC_CAUSE_WDT       3'h2
`define SMRC_CAUSE_SOFT      3'h4
`define SMRC_CLKST_RESET     1'h1

// Clock ratios
`define SMRC_XTAL_HZ         16000000
`define SMRC_PLL_HZ          240000000
`define SMRC_CODEC_HZ        800000
`define SMRC_PLL_MULT        4'hF
`define SMRC_HOST_DIV        3'h6
`define SMRC_HOST_DIV_SLOW   3'h7
`define SMRC_DSP_DIV         3'h4
`define SMRC_LP_DIV0         10'h001
`define SMRC_LP_DIV1         10'h010
`define SMRC_LP_DIV2         10'h040
`define SMRC_LP_DIV3         10'h200

// Timing
`define SMRC_CORE_CLK_HZ     25000000
`define SMRC_CHIP_RST_CYCLES 5'h10
`define SMRC_BOOT_WAIT_S     3

`endif

// ===== logic/smrc_pkg.sv
// Types of the system mode and reset controller
package smrc_pkg;
	typedef enum logic [1:0] {CLK_SLOW, CLK_WAIT_LOCK, CLK_FAST} clk_state_e;
	typedef logic [31:0] word_t;
endpackage

// ===== logic/sysctl_if.sv
// Signals between the mode controller and its reset and clock helpers
`timescale 1ns/1ps
`default_nettype none
interface sysctl_if;
	logic soft_req;
	logic wdt_req;
	logic chip_rst_active;
	logic rst_release;
	logic low_power;
	logic clk_status;
	logic fast_sel;
	modport rst_side (input soft_req, input wdt_req, output chip_rst_active, output rst_release);
	modport clk_side (input low_power, input chip_rst_active, output clk_status, output fast_sel);
	modport ctrl (output soft_req, output wdt_req, output low_power, input chip_rst_active,
		input rst_release, input clk_status, input fast_sel);
endinterface
`default_nettype wire

// ===== logic/chip_reset_gen.sv
// Chip reset stretcher for watchdog and software reset requests
`timescale 1ns/1ps
`default_nettype none
`include "smrc_consts.svh"
module chip_reset_gen (
	input  wire logic     core_clk,
	input  wire logic     arst_n,
	sysctl_if.rst_side    ctl
);
	logic [4:0] cnt_q;
	logic       active_q;

	// Every source restarts the full stretch, so overlapping requests merge
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			cnt_q    <= `SMRC_CHIP_RST_CYCLES;
			active_q <= 1'b1;
		end
		else if (ctl.soft_req || ctl.wdt_req)
		begin
			cnt_q    <= `SMRC_CHIP_RST_CYCLES;
			active_q <= 1'b1;
		end
		else if (cnt_q != 5'h00)
		begin
			cnt_q <= cnt_q - 5'h01;
		end
		else
		begin
			active_q <= 1'b0;
		end
	end

	assign ctl.chip_rst_active = active_q;
	assign ctl.rst_release     = active_q && (cnt_q == 5'h00) && !ctl.soft_req && !ctl.wdt_req;
endmodule // chip_reset_gen
`default_nettype wire

// ===== logic/clock_switch_ctrl.sv
// Slow and fast clock switch-over with PLL lock wait
`timescale 1ns/1ps
`default_nettype none
`include "smrc_consts.svh"
module clock_switch_ctrl (
	input  wire logic     core_clk,
	input  wire logic     arst_n,
	input  wire logic     pll_lock,
	sysctl_if.clk_side    ctl
);
	logic                  lock_s1_q;
	logic                  lock_s2_q;
	smrc_pkg::clk_state_e  state_q;

	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			lock_s1_q <= 1'b0;
			lock_s2_q <= 1'b0;
		end
		else
		begin
			lock_s1_q <= pll_lock;
			lock_s2_q <= lock_s1_q;
		end
	end

	// Fast clock is only taken once the PLL reports lock
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
			state_q <= smrc_pkg::CLK_SLOW;
		else if (ctl.chip_rst_active || ctl.low_power)
			state_q <= smrc_pkg::CLK_SLOW;
		else
		begin
			case (state_q)
				smrc_pkg::CLK_SLOW:      state_q <= smrc_pkg::CLK_WAIT_LOCK;
				smrc_pkg::CLK_WAIT_LOCK: if (lock_s2_q) state_q <= smrc_pkg::CLK_FAST;
				default:                 state_q <= smrc_pkg::CLK_FAST;
			endcase
		end
	end

	assign ctl.fast_sel   = (state_q == smrc_pkg::CLK_FAST);
	assign ctl.clk_status = (state_q != smrc_pkg::CLK_FAST);
endmodule // clock_switch_ctrl
`default_nettype wire

// ===== logic/system_mode_reset_control.sv
// System mode, reset and clock controller on the peripheral bus
`timescale 1ns/1ps
`default_nettype none
`include "smrc_consts.svh"

// How it works
// - Own 16 Kbyte window at peripheral base
// - Any chip reset restores mode register defaults except remap bit 0; reset cause kept
// - Pin, watchdog and software reset chip
// - Bit 11 remap low, bit 10 high
// - DSP stays reset until host write
// - Boot pin sampled at reset release
// - PLL multiplies crystal by fifteen
// - Host divides by six, or seven with bit 7 set; DSP four
// - Codec clock 800 kHz, independent
// - Remap low maps ROM at 1K
// - Remap high maps region zero 16M
// - Remap loads from pin, software sets
// - DSP release bit resets low
// - DSP clock inhibit resets low
// - ROM boot drives CTS, waits seconds
// - Registers reached as an APB slave
// - Reset cause recorded one-hot
// - Low power stops PLL, relock switches
// - Clock status one on slow clock
module system_mode_reset_control #(
	parameter int unsigned BOOT_WAIT_CYCLES = `SMRC_BOOT_WAIT_S * `SMRC_CORE_CLK_HZ,
	parameter logic [15:0] DEVICE_IDENT     = 16'h5A3C // Arbitrary value
) (
	input  wire logic        core_clk,
	input  wire logic        arst_n,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        wdt_reset_pulse,
	input  wire logic        boot_select_pin,
	input  wire logic        package_size_flag,
	input  wire logic        pll_lock,
	input  wire logic        boot_header_seen,
	input  wire logic [31:0] host_addr,
	output logic             chip_rst_n,
	output logic             dsp_a_rst_n,
	output logic             dsp_a_clk_en,
	output logic             boot_remap_flag,
	output logic             boot_rom_sel,
	output logic             external_chip_select_zero_sel,
	output logic             pll_enable,
	output logic      [3:0]  pll_mult,
	output logic      [2:0]  host_clk_div,
	output logic      [2:0]  dsp_clk_div,
	output logic      [8:0]  codec_clk_div,
	output logic      [9:0]  lp_clk_div,
	output logic             fast_clk_sel,
	output logic             boot_cts_active,
	output logic             boot_wait_active
);
	localparam logic [8:0] CODEC_DIV = 9'(`SMRC_PLL_HZ / `SMRC_CODEC_HZ);

	sysctl_if ctl ();

	smrc_pkg::word_t mode_q;
	logic [2:0]      cause_q;
	logic            remap_q;
	logic            next_remap_q;
	logic            next_remap_valid_q;
	logic            pkg_q;
	logic            boot_s1_q;
	logic            boot_s2_q;
	logic            pkg_s1_q;
	logic            pkg_s2_q;
	logic [26:0]     boot_cnt_q;
	logic            boot_wait_q;
	logic            in_window;
	logic [13:0]     offset;
	logic            hit_mode;
	logic            hit_ident;
	logic            hit_cause;
	logic            hit_clkst;
	logic            bus_write;
	logic            soft_low;
	logic            soft_high;
	smrc_pkg::word_t prdata_d;
	smrc_pkg::word_t prdata_q;

	chip_reset_gen u_rst (
		.core_clk (core_clk),
		.arst_n   (arst_n),
		.ctl      (ctl.rst_side)
	);

	clock_switch_ctrl u_clk (
		.core_clk (core_clk),
		.arst_n   (arst_n),
		.pll_lock (pll_lock),
		.ctl      (ctl.clk_side)
	);

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers

	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			boot_s1_q <= 1'b0;
			boot_s2_q <= 1'b0;
			pkg_s1_q  <= 1'b0;
			pkg_s2_q  <= 1'b0;
		end
		else
		begin
			boot_s1_q <= boot_select_pin;
			boot_s2_q <= boot_s1_q;
			pkg_s1_q  <= package_size_flag;
			pkg_s2_q  <= pkg_s1_q;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Bus decode

	assign in_window = (paddr[31:`SMRC_WIN_BITS] == 18'(`SMRC_BASE_ADDR >> `SMRC_WIN_BITS));
	assign offset    = paddr[`SMRC_WIN_BITS-1:0];

	always_comb
	begin
		hit_mode  = 1'b0;
		hit_ident = 1'b0;
		hit_cause = 1'b0;
		hit_clkst = 1'b0;
		if (!in_window)
			hit_mode = 1'b0;
		else if (offset == `SMRC_OFF_MODE)
			hit_mode = 1'b1;
		else if (offset == `SMRC_OFF_IDENT)
			hit_ident = 1'b1;
		else if (offset == `SMRC_OFF_CAUSE)
			hit_cause = 1'b1;
		else if (offset == `SMRC_OFF_CLKST)
			hit_clkst = 1'b1;
	end

	// Writes during the chip reset stretch are dropped
	assign bus_write = psel && penable && pwrite && !ctl.chip_rst_active;
	assign pready    = 1'b1;
	assign pslverr   = psel && penable && !(hit_mode || hit_ident || hit_cause || hit_clkst);

	assign soft_low  = bus_write && hit_mode && pwdata[`SMRC_SOFT_LOW_BIT];
	assign soft_high = bus_write && hit_mode && pwdata[`SMRC_SOFT_HIGH_BIT];
	assign ctl.soft_req  = soft_low || soft_high;
	assign ctl.wdt_req   = wdt_reset_pulse;
	assign ctl.low_power = mode_q[`SMRC_LP_BIT];

	always_comb
	begin
		prdata_d = 32'h00000000;
		if (hit_mode)
			prdata_d = {mode_q[31:1], remap_q};
		else if (hit_ident)
			prdata_d = {15'h0000, pkg_q, DEVICE_IDENT};
		else if (hit_cause)
			prdata_d = {29'h00000000, cause_q};
		else if (hit_clkst)
			prdata_d = {31'h00000000, ctl.clk_status};
	end

	// Captured in the setup phase, so it stands through the access phase
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
			prdata_q <= 32'h00000000;
		else if (psel && !penable)
			prdata_q <= prdata_d;
	end

	assign prdata = prdata_q;

	////////////////////////////////////////////////////////////////////////
	// Registers

	// Software reset bits never stored, so they read zero
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
			mode_q <= `SMRC_MODE_RESET;
		else if (ctl.chip_rst_active)
			mode_q <= `SMRC_MODE_RESET;
		else if (bus_write && hit_mode && !ctl.soft_req)
			mode_q <= pwdata & `SMRC_MODE_WMASK;
	end

	// Soft reset choice survives the stretch that follows it unless a watchdog request clears it
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			next_remap_q       <= 1'b0;
			next_remap_valid_q <= 1'b0;
		end
		else if (ctl.soft_req)
		begin
			next_remap_q       <= soft_high && !soft_low;
			next_remap_valid_q <= 1'b1;
		end
		else if (ctl.wdt_req)
			next_remap_valid_q <= 1'b0;
		else if (ctl.rst_release)
			next_remap_valid_q <= 1'b0;
	end

	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
			remap_q <= 1'b0;
		else if (ctl.rst_release)
			remap_q <= next_remap_valid_q ? next_remap_q : boot_s2_q;
		else if (ctl.chip_rst_active)
			remap_q <= 1'b0;
		else if (bus_write && hit_mode && !ctl.soft_req)
			remap_q <= pwdata[`SMRC_REMAP_BIT];
	end

	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
			pkg_q <= 1'b0;
		else if (ctl.rst_release)
			pkg_q <= pkg_s2_q;
	end

	// Latest source wins, software over watchdog in one cycle; the cause itself outlives chip reset
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
			cause_q <= `SMRC_CAUSE_HW;
		else if (ctl.soft_req)
			cause_q <= `SMRC_CAUSE_SOFT;
		else if (ctl.wdt_req)
			cause_q <= `SMRC_CAUSE_WDT;
		else if (bus_write && hit_cause)
			cause_q <= pwdata[2:0];
	end

	////////////////////////////////////////////////////////////////////////
	// Boot wait window

	// Software ends it early by reporting the download header
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			boot_cnt_q  <= 27'h0000000;
			boot_wait_q <= 1'b0;
		end
		else if (ctl.rst_release)
		begin
			// Last count is the final waiting cycle, hence one less
			boot_cnt_q  <= 27'(BOOT_WAIT_CYCLES - 1);
			boot_wait_q <= !(next_remap_valid_q ? next_remap_q : boot_s2_q);
		end
		else if (ctl.chip_rst_active || boot_header_seen || boot_cnt_q == 27'h0000000)
			boot_wait_q <= 1'b0;
		else if (boot_wait_q)
			boot_cnt_q <= boot_cnt_q - 27'h0000001;
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs

	assign chip_rst_n   = !ctl.chip_rst_active;
	// follows the stored release bit; held low during chip reset
	assign dsp_a_rst_n  = mode_q[`SMRC_DSP_REL_BIT] && !ctl.chip_rst_active;
	assign dsp_a_clk_en = !mode_q[`SMRC_DSP_INH_BIT];
	assign boot_remap_flag = remap_q;
	assign boot_rom_sel    = !remap_q && (host_addr[31:10] == 22'h000000);
	assign external_chip_select_zero_sel = remap_q && (host_addr[31:24] == 8'h00);
	assign fast_clk_sel    = ctl.fast_sel;
	assign boot_cts_active = boot_wait_q;
	assign boot_wait_active = boot_wait_q;

	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			pll_enable    <= 1'b0;
			pll_mult      <= `SMRC_PLL_MULT;
			host_clk_div  <= `SMRC_HOST_DIV;
			dsp_clk_div   <= `SMRC_DSP_DIV;
			codec_clk_div <= CODEC_DIV;
			lp_clk_div    <= `SMRC_LP_DIV3;
		end
		else
		begin
			pll_enable    <= !mode_q[`SMRC_LP_BIT];
			pll_mult      <= `SMRC_PLL_MULT;
			host_clk_div  <= mode_q[`SMRC_SLOW_HOST_BIT] ? `SMRC_HOST_DIV_SLOW : `SMRC_HOST_DIV;
			dsp_clk_div   <= `SMRC_DSP_DIV;
			codec_clk_div <= CODEC_DIV;
			case (mode_q[`SMRC_LPCS_LSB +: 2])
				2'h0:    lp_clk_div <= `SMRC_LP_DIV0;
				2'h1:    lp_clk_div <= `SMRC_LP_DIV1;
				2'h2:    lp_clk_div <= `SMRC_LP_DIV2;
				default: lp_clk_div <= `SMRC_LP_DIV3;
			endcase
		end
	end
endmodule // system_mode_reset_control
`default_nettype wire

// ===== tb/smrc_assertions.sv
// Port-level checker for the system mode and reset controller
`timescale 1ns/1ps
`default_nettype none
module smrc_assertions #(
	parameter int unsigned BOOT_WAIT_CYCLES = 50
) (
	input wire logic        core_clk,
	input wire logic        arst_n,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pslverr,
	input wire logic        wdt_reset_pulse,
	input wire logic        pll_lock,
	input wire logic [31:0] host_addr,
	input wire logic        chip_rst_n,
	input wire logic        dsp_a_rst_n,
	input wire logic        boot_remap_flag,
	input wire logic        boot_rom_sel,
	input wire logic        external_chip_select_zero_sel,
	input wire logic        pll_enable,
	input wire logic [3:0]  pll_mult,
	input wire logic [2:0]  dsp_clk_div,
	input wire logic [8:0]  codec_clk_div,
	input wire logic        fast_clk_sel,
	input wire logic        boot_wait_active
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!arst_n);
	////////////////////////////////////////////////////////////////
	// Boot wait length, counted here since it exceeds any repetition
	logic [31:0] wait_cnt_q;
	always_ff @(posedge core_clk or negedge arst_n)
		if (!arst_n)
			wait_cnt_q <= 32'h0;
		else if (boot_wait_active)
			wait_cnt_q <= wait_cnt_q + 32'h1;
		else
			wait_cnt_q <= 32'h0;
	////////////////////////////////////////////////////////////////
	AST_OUT_WIN: assert property (psel && penable && paddr[31:14] != 18'h3FC00 |-> pslverr)
		else $error("access outside window not refused");
	AST_UNMAP: assert property (psel && penable && !pwrite && paddr[31:14] == 18'h3FC00 &&
		paddr[13:4] != 10'h000 |-> pslverr && prdata == 32'h0)
		else $error("unmapped read not refused");
	AST_WDT: assert property (wdt_reset_pulse && chip_rst_n |=> !chip_rst_n [*8])
		else $error("watchdog pulse gave no chip reset");
	AST_SOFT: assert property (psel && penable && pwrite && chip_rst_n && paddr == 32'hFF000000 &&
		(pwdata[11] || pwdata[10]) |=> !chip_rst_n [*8])
		else $error("software reset write gave no chip reset");
	AST_REL_LEN: assert property ($rose(chip_rst_n) |-> !$past(chip_rst_n, 16))
		else $error("chip reset too short");
	AST_DSP_HOLD: assert property (!chip_rst_n |-> !dsp_a_rst_n)
		else $error("dsp released during chip reset");
	AST_ROM_SEL: assert property (boot_rom_sel == (!boot_remap_flag && host_addr[31:10] == 22'h0))
		else $error("boot rom decode wrong");
	AST_CS0_SEL: assert property (external_chip_select_zero_sel ==
		(boot_remap_flag && host_addr[31:24] == 8'h00))
		else $error("region zero decode wrong");
	AST_RATIOS: assert property (chip_rst_n && $past(chip_rst_n) |->
		pll_mult == 4'hF && dsp_clk_div == 3'h4 && codec_clk_div == 9'h12C)
		else $error("clock ratio wrong");
	AST_FAST_PLL: assert property (fast_clk_sel |-> pll_enable)
		else $error("fast clock with pll stopped");
	AST_FAST_LOCK: assert property ($rose(fast_clk_sel) |-> $past(pll_lock))
		else $error("fast clock before lock");
	AST_WAIT_ROM: assert property (boot_wait_active |-> !boot_remap_flag && wait_cnt_q < BOOT_WAIT_CYCLES)
		else $error("boot wait wrong");
endmodule // smrc_assertions
bind system_mode_reset_control smrc_assertions #(.BOOT_WAIT_CYCLES(BOOT_WAIT_CYCLES)) chk (
	.core_clk                      (core_clk),
	.arst_n                        (arst_n),
	.psel                          (psel),
	.penable                       (penable),
	.pwrite                        (pwrite),
	.paddr                         (paddr),
	.pwdata                        (pwdata),
	.prdata                        (prdata),
	.pslverr                       (pslverr),
	.wdt_reset_pulse               (wdt_reset_pulse),
	.pll_lock                      (pll_lock),
	.host_addr                     (host_addr),
	.chip_rst_n                    (chip_rst_n),
	.dsp_a_rst_n                   (dsp_a_rst_n),
	.boot_remap_flag               (boot_remap_flag),
	.boot_rom_sel                  (boot_rom_sel),
	.external_chip_select_zero_sel (external_chip_select_zero_sel),
	.pll_enable                    (pll_enable),
	.pll_mult                      (pll_mult),
	.dsp_clk_div                   (dsp_clk_div),
	.codec_clk_div                 (codec_clk_div),
	.fast_clk_sel                  (fast_clk_sel),
	.boot_wait_active              (boot_wait_active)
);
`default_nettype wire

// ===== tb/apb_host_model.sv
// Host processor side of the peripheral bus
`timescale 1ns/1ps
`default_nettype none
module apb_host_model (
	input  wire logic        core_clk,
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	input  wire logic        pslverr,
	output var  logic        psel,
	output var  logic        penable,
	output var  logic        pwrite,
	output var  logic [31:0] paddr,
	output var  logic [31:0] pwdata
);
	logic tmo = 1'b0;
	initial
	begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 32'h0;
		pwdata = 32'h0;
	end
	// Entered just after a rising edge; returns after one idle cycle
	task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		int n;
		psel = 1'b1;
		pwrite = w;
		paddr = a;
		pwdata = d;
		@(posedge core_clk);
		#1 penable = 1'b1;
		n = 0;
		do
		begin
			@(posedge core_clk);
			n++;
		end
		while (pready !== 1'b1 && n < 8);
		q = prdata;
		e = pslverr;
		if (pready !== 1'b1)
			tmo = 1'b1;
		// Idle lines show no stale value
		#1 psel = 1'b0;
		penable = 1'b0;
		paddr = ~a;
		pwdata = ~d;
		// Idle edge keeps the next call from re-raising psel at once
		@(posedge core_clk);
		#1;
	endtask
endmodule // apb_host_model
`default_nettype wire

// ===== tb/tb.sv
// Directed testbench of the system mode and reset controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, s) begin n_tests++; if ((s) !== (e)) begin miscompares++; \
	$display("CHECK FAILED %s exp %h got %h", nm, e, s); end end
module tb;
	logic        core_clk, arst_n, psel, penable, pwrite, pready, pslverr, wdt, boot_pin, pkg, lock, hdr;
	logic [31:0] paddr, pwdata, prdata, host_addr, q;
	logic        e, chip_rst_n, dsp_rst_n, dsp_clk_en, remap, rom_sel, cs0_sel, pll_en, fast, cts, bwait;
	logic [3:0]  mult;
	logic [2:0]  hdiv, ddiv;
	logic [8:0]  cdiv;
	logic [9:0]  lpdiv;
	int          miscompares = 0, n_tests = 0;
	logic [9:0]  lp_tab [4] = '{10'h001, 10'h010, 10'h040, 10'h200};
	system_mode_reset_control #(.BOOT_WAIT_CYCLES(50)) dut (.core_clk(core_clk), .arst_n(arst_n),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .wdt_reset_pulse(wdt), .boot_select_pin(boot_pin),
		.package_size_flag(pkg), .pll_lock(lock), .boot_header_seen(hdr), .host_addr(host_addr),
		.chip_rst_n(chip_rst_n), .dsp_a_rst_n(dsp_rst_n), .dsp_a_clk_en(dsp_clk_en), .boot_remap_flag(remap),
		.boot_rom_sel(rom_sel), .external_chip_select_zero_sel(cs0_sel), .pll_enable(pll_en),
		.pll_mult(mult), .host_clk_div(hdiv), .dsp_clk_div(ddiv), .codec_clk_div(cdiv), .lp_clk_div(lpdiv),
		.fast_clk_sel(fast), .boot_cts_active(cts), .boot_wait_active(bwait));
	apb_host_model host (.core_clk(core_clk), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
	initial
	begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end
	////////////////////////////////////////////////////////////////
	task automatic results();
		$display("comparisons %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	task automatic acc(input logic w, input logic [31:0] a, input logic [31:0] d);
		host.xfer(w, a, d, q, e);
		if (host.tmo)
		begin
			miscompares++;
			results();
		end
	endtask
	task automatic rd(input string nm, input logic [31:0] a, input logic [31:0] x);
		acc(1'b0, a, 32'h0);
		`CHK(nm, x, q)
		`CHK("pslverr", 1'b0, e)
	endtask
	// Bounded wait for the chip reset to end
	task automatic wait_up();
		int n;
		n = 0;
		while (chip_rst_n !== 1'b1 && n < 40)
		begin
			cyc(1);
			n++;
		end
		if (chip_rst_n !== 1'b1)
		begin
			miscompares++;
			results();
		end
	endtask
	////////////////////////////////////////////////////////////////
	initial
	begin
		{arst_n, wdt, boot_pin, lock, hdr} = 5'h00;
		pkg = 1'b1;
		host_addr = 32'h0;
		cyc(6);
		arst_n = 1'b1;
		wait_up();
		`CHK("cts", 1'b1, cts)
		hdr = 1'b1;
		cyc(2);
		hdr = 1'b0;
		`CHK("wait", 1'b0, bwait)
		rd("mode", 32'hFF000000, 32'h000B0340);
		rd("ident", 32'hFF000004, 32'h00015A3C);
		rd("cause", 32'hFF000008, 32'h00000001);
		rd("clkst", 32'hFF00000C, 32'h00000001);
		`CHK("dsp rst", 1'b0, dsp_rst_n)
		`CHK("dsp clk", 1'b1, dsp_clk_en)
		`CHK("ratios", {4'hF, 3'h6, 3'h4, 9'h12C}, {mult, hdiv, ddiv, cdiv})
		acc(1'b0, 32'hFF000010, 32'h0);
		`CHK("unmapped", 33'h100000000, {e, q})
		acc(1'b1, 32'hFF004000, 32'h000B0341);
		`CHK("outside", 1'b1, e)
		rd("mode kept", 32'hFF000000, 32'h000B0340);
		host_addr = 32'h000003FF;
		cyc(1);
		`CHK("rom sel", 2'b10, {rom_sel, cs0_sel})
		host_addr = 32'h00000400;
		cyc(1);
		`CHK("rom end", 2'b00, {rom_sel, cs0_sel})
		for (int i = 0; i < 4; i++)
		begin
			acc(1'b1, 32'hFF000000, 32'h000B0040 | (i << 8) | (i == 3 ? 32'h80 : 32'h0));
			cyc(1);
			`CHK("lp div", lp_tab[i], lpdiv)
		end
		`CHK("slow host", 3'h7, hdiv)
		for (int i = 0; i < 3; i++)
		begin
			acc(1'b1, 32'hFF000000, 32'h000B0342);
			`CHK("dsp go", 1'b1, dsp_rst_n)
			acc(1'b1, 32'hFF000000, 32'h000B0340);
			`CHK("dsp hold", 1'b0, dsp_rst_n)
		end
		acc(1'b1, 32'hFF000000, 32'h000B0348);
		`CHK("dsp inhibit", 1'b0, dsp_clk_en)
		lock = 1'b1;
		acc(1'b1, 32'hFF000000, 32'h000B0300);
		for (int n = 0; n < 10 && fast !== 1'b1; n++)
			cyc(1);
		`CHK("fast", 2'b11, {fast, pll_en})
		rd("clkst fast", 32'hFF00000C, 32'h00000000);
		acc(1'b1, 32'hFF000000, 32'h000B0341);
		cyc(1);
		`CHK("slow", 2'b00, {fast, pll_en})
		rd("clkst slow", 32'hFF00000C, 32'h00000001);
		`CHK("remap sw", 1'b1, remap)
		host_addr = 32'h00FFFFFF;
		cyc(1);
		`CHK("cs0 sel", 2'b01, {rom_sel, cs0_sel})
		host_addr = 32'h01000000;
		cyc(1);
		`CHK("cs0 end", 2'b00, {rom_sel, cs0_sel})
		acc(1'b1, 32'hFF000008, 32'h0);
		rd("cause wr", 32'hFF000008, 32'h0);
		for (int b = 11; b >= 10; b--)
		begin
			acc(1'b1, 32'hFF000000, 32'h1 << b);
			acc(1'b1, 32'hFF000000, 32'h000B0341);
			wait_up();
			rd("soft mode", 32'hFF000000, 32'h000B0340 | (b == 10));
			rd("soft cause", 32'hFF000008, 32'h4);
			`CHK("soft dsp", 1'b0, dsp_rst_n)
			`CHK("soft wait", b == 11, bwait)
			cyc(43);
			`CHK("wait held", b == 11, bwait)
			cyc(12);
			`CHK("wait end", 1'b0, bwait)
		end
		boot_pin = 1'b1;
		wdt = 1'b1;
		cyc(1);
		wdt = 1'b0;
		wait_up();
		rd("wdt cause", 32'hFF000008, 32'h2);
		rd("wdt mode", 32'hFF000000, 32'h000B0341);
		boot_pin = 1'b0;
		arst_n = 1'b0;
		cyc(10);
		arst_n = 1'b1;
		wait_up();
		rd("hw cause", 32'hFF000008, 32'h1);
		rd("hw mode", 32'hFF000000, 32'h000B0340);
		results();
	end
endmodule // tb
`default_nettype wire
